//--- core/czc_top.sv
`timescale 1ns/1ns
`include "czc_defines.svh"

// ----------------------------------------
// Pin synchroniser
// ----------------------------------------
module czc_sync #(
	parameter int W = 12
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_nxt;
	// A bit moves only once the two late stages agree
	genvar b;
	for (b = 0; b < W; b++)
	begin : g_b
		assign q_nxt[b] = (s2_r[b] == s3_r[b]) ? s3_r[b] : o_q[b];
	end
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			o_q <= '0;
		end
		else
		begin
			s1_r <= i_d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			o_q <= q_nxt;
		end
	end
endmodule // czc_sync

module czc_top #(
	parameter int P_MS_CYC = `CZC_CLK_HZ / `CZC_MS_PER_S
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire czc_pkg::czc_pins_in_t i_pins,
	output czc_pkg::czc_pins_out_t o_pins,
	output logic [12:0] o_speed,
	output logic o_wd_trip
);
	czc_pkg::czc_pins_in_t pin_s;
	czc_pkg::czc_pins_out_t pins_nxt;
	czc_pkg::czc_wd_t wd_r;
	czc_pkg::czc_wd_t wd_nxt;
	logic [4:0] ctrl_r;
	logic [7:0] ptype_r;
	logic [12:0] rspd_r;
	logic [12:0] bspd_r;
	logic [15:0] outv_r;
	logic [1:0] hso_r;
	logic [5:0] node_r;
	logic [15:0] epr_r;
	logic [3:0] zrun_r;
	logic [3:0] zrun_nxt;
	logic [15:0] rdata_nxt;
	logic [31:0] tick_r;
	logic [15:0] ms_r;
	logic acc;
	czc_pkg::czc_rel_t rel;
	logic wd_act;
	logic gbyp;
	logic poll;
	logic ms_tick;
	logic trip;
	logic kill;
	logic ds_ready;
	logic us_send;
	logic us_ready;
	logic ds_send;
	logic [3:0] occ;
	logic [12:0] wclip;
	logic [3:0] m_hs;
	logic [3:0] m_run;
	logic [3:0] m_byp;
	logic [3:0] m_dir;

	czc_sync #(
		.W(12)
	) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_d(i_pins),
		.o_q(pin_s)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign acc = ctrl_r[`CZC_B_MODE] == `CZC_MODE_ACC;
	assign rel = czc_pkg::czc_rel_t'(ctrl_r[`CZC_B_REL_HI:`CZC_B_REL_LO]);
	assign wd_act = ctrl_r[`CZC_B_WDACT];
	assign gbyp = ctrl_r[`CZC_B_GBYP];
	assign m_hs = outv_r[3:0];
	assign m_run = outv_r[7:4];
	assign m_byp = outv_r[11:8];
	assign m_dir = outv_r[15:12];
	assign ds_ready = hso_r[0];
	assign us_send = hso_r[1];
	// Values past the field width clip to the top speed
	assign wclip = (i_wdata > 16'(`CZC_SPD_MAX)) ? `CZC_SPD_MAX
		: i_wdata[12:0];
	// Any output-variable write counts as a poll
	assign poll = i_wr && (i_addr == `CZC_A_OUTV || i_addr == `CZC_A_HSO);

	// ----------------------------------------
	// Poll watchdog
	// ----------------------------------------
	assign ms_tick = tick_r == 32'(P_MS_CYC - 1);
	assign trip = wd_r == czc_pkg::CZC_WD_TRIP;
	// Action zero drops the handshake, run and bypass outputs; action one holds them
	assign kill = trip && !wd_act;
	always_comb
	begin
		wd_nxt = wd_r;
		case (wd_r)
			czc_pkg::CZC_WD_IDLE:
				if (poll)
					wd_nxt = czc_pkg::CZC_WD_LIVE;
			czc_pkg::CZC_WD_LIVE:
				if (!poll && ms_tick && ms_r + 16'h0001 >= epr_r)
					wd_nxt = czc_pkg::CZC_WD_TRIP;
			czc_pkg::CZC_WD_TRIP:
				if (poll)
					wd_nxt = czc_pkg::CZC_WD_LIVE;
			default:
				wd_nxt = czc_pkg::CZC_WD_IDLE;
		endcase
	end

	// ----------------------------------------
	// Accumulation zones
	// ----------------------------------------
	// Zone sensors arrive on the sending lines
	assign occ = pin_s.hs;
	genvar z;
	for (z = 0; z < 4; z++)
	begin : g_zone
		logic n_occ;
		logic n_run;
		logic feed;
		logic permit;
		if (z < 3)
		begin : g_mid
			assign n_occ = occ[z+1];
			assign n_run = zrun_r[z+1];
		end
		else
		begin : g_last
			assign n_occ = !ds_ready;
			assign n_run = ds_ready;
		end
		if (z > 0)
		begin : g_fed
			assign feed = zrun_r[z-1] && occ[z-1];
		end
		else
		begin : g_first
			assign feed = us_send;
		end
		assign permit = (rel == czc_pkg::CZC_REL_SING) ? !n_occ
			: (rel == czc_pkg::CZC_REL_QUICK) ? (!n_occ || n_run)
			: (!n_occ || n_run);
		// Train keeps an empty zone rolling behind a moving one
		assign zrun_nxt[z] = acc && !gbyp && !kill
			&& ((occ[z] && permit) || (!occ[z] && feed)
			|| (rel == czc_pkg::CZC_REL_TRAIN && zrun_r[z] && n_run));
	end
	assign us_ready = !occ[0];
	assign ds_send = occ[3] && zrun_r[3];

	// ----------------------------------------
	// Port outputs
	// ----------------------------------------
	genvar p;
	for (p = 0; p < 4; p++)
	begin : g_port
		logic [1:0] pt;
		logic drv;
		assign pt = ptype_r[2*p+1:2*p];
		assign drv = acc || pt == `CZC_PT_DRV;
		// Driver ports leave the handshake output quiet
		assign pins_nxt.hs[p] = !kill && !drv && m_hs[p];
		// Bypass hands the run line to the host for purging
		assign pins_nxt.run[p] = !kill && ((acc && !gbyp) ? zrun_r[p]
			: m_run[p]);
		assign pins_nxt.byp[p] = !kill && (acc ? gbyp : m_byp[p]);
		assign pins_nxt.dir[p] = pin_s.dir[p]
			|| (!acc && drv && m_dir[p]);
		assign pins_nxt.fault[p] = pin_s.fault[p];
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb
	begin
		rdata_nxt = 16'h0000;
		case (i_addr)
			`CZC_A_CTRL: rdata_nxt = {11'h000, ctrl_r};
			`CZC_A_PTYPE: rdata_nxt = {8'h00, ptype_r};
			`CZC_A_RSPD: rdata_nxt = {3'h0, rspd_r};
			`CZC_A_BSPD: rdata_nxt = {3'h0, bspd_r};
			`CZC_A_OUTV: rdata_nxt = outv_r;
			`CZC_A_HSO: rdata_nxt = {14'h0000, hso_r};
			`CZC_A_INV: rdata_nxt = {4'h0, pin_s.dir, pin_s.fault,
				pin_s.hs};
			`CZC_A_HSI: rdata_nxt = {14'h0000, ds_send, us_ready};
			`CZC_A_NODE: rdata_nxt = {10'h000, node_r};
			`CZC_A_EPR: rdata_nxt = epr_r;
			`CZC_A_STAT: rdata_nxt = {14'h0000, trip,
				wd_r != czc_pkg::CZC_WD_IDLE};
			default: rdata_nxt = 16'h0000;
		endcase
		if (!i_rd)
			rdata_nxt = 16'h0000;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctrl_r <= 5'h00;
			ptype_r <= 8'h00;
			rspd_r <= 13'h0000;
			bspd_r <= 13'h0000;
			outv_r <= 16'h0000;
			hso_r <= 2'h0;
			node_r <= `CZC_NODE_RST;
			epr_r <= `CZC_EPR_RST;
		end
		else if (i_wr)
		begin
			case (i_addr)
				`CZC_A_CTRL: ctrl_r <= i_wdata[4:0];
				`CZC_A_PTYPE: ptype_r <= i_wdata[7:0];
				`CZC_A_RSPD: rspd_r <= wclip;
				`CZC_A_BSPD: bspd_r <= wclip;
				`CZC_A_OUTV: outv_r <= i_wdata;
				`CZC_A_HSO: hso_r <= i_wdata[1:0];
				`CZC_A_NODE: node_r <= i_wdata[5:0];
				`CZC_A_EPR: epr_r <= i_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tick_r <= 32'h0000_0000;
			ms_r <= 16'h0000;
			wd_r <= czc_pkg::CZC_WD_IDLE;
		end
		else
		begin
			tick_r <= (poll || ms_tick) ? 32'h0000_0000
				: tick_r + 32'h0000_0001;
			ms_r <= poll ? 16'h0000 : ms_tick ? ms_r + 16'h0001 : ms_r;
			wd_r <= wd_nxt;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			zrun_r <= 4'h0;
			o_pins <= '0;
			o_speed <= 13'h0000;
			o_rdata <= 16'h0000;
			o_wd_trip <= 1'b0;
		end
		else
		begin
			zrun_r <= zrun_nxt;
			o_pins <= pins_nxt;
			o_speed <= gbyp ? bspd_r : rspd_r;
			o_rdata <= rdata_nxt;
			o_wd_trip <= trip;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic node_wr_r;
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			node_wr_r <= 1'b0;
		else if (i_wr && i_addr == `CZC_A_NODE)
			node_wr_r <= 1'b1;
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	a_fault_echo: assert property (
		##1 o_pins.fault == $past(pin_s.fault))
		else $error("fault echo wrong");
	a_dir_echo: assert property (
		##1 ((o_pins.dir & $past(pin_s.dir)) == $past(pin_s.dir)))
		else $error("direction echo lost");
	a_bypass_stop: assert property (
		(acc && gbyp) |=> zrun_r == 4'h0 ##1 o_pins.run == $past(m_run)
			|| $past(kill) || !$past(acc && gbyp))
		else $error("zones ran under bypass");
	a_speed_pick: assert property (
		##1 o_speed == ($past(gbyp) ? $past(bspd_r) : $past(rspd_r)))
		else $error("speed select wrong");
	a_speed_clip: assert property (
		(i_wr && i_addr == `CZC_A_RSPD && i_wdata > 16'(`CZC_SPD_MAX))
		|=> rspd_r == `CZC_SPD_MAX)
		else $error("speed not clipped");
	a_node_default: assert property (
		!node_wr_r |-> node_r == `CZC_NODE_RST)
		else $error("node address lost default");
	a_acc_driver: assert property (
		acc |=> o_pins.hs == 4'h0)
		else $error("handshake out in accumulation");
	a_manual_run: assert property (
		(!acc && !kill) |=> o_pins.run == $past(m_run))
		else $error("manual run not direct");
	a_drv_quiet: assert property (
		(!acc && ptype_r[1:0] == `CZC_PT_DRV) |=> !o_pins.hs[0])
		else $error("driver port drives handshake");
	a_us_ready: assert property (
		(i_rd && i_addr == `CZC_A_HSI)
		|=> o_rdata[0] == !$past(occ[0]))
		else $error("upstream ready wrong");
	a_wd_clear: assert property (
		(trip && poll) |=> !trip ##1 !o_wd_trip)
		else $error("poll did not clear timeout");
	c_trip: cover property (!trip ##1 trip);
	c_purge: cover property (acc && gbyp && o_pins.run != 4'h0);
	c_release: cover property (acc && zrun_r[3] && occ[3]);
endmodule // czc_top

//--- inc/czc_defines.svh
`ifndef CZC_DEFINES_SVH
`define CZC_DEFINES_SVH
// ----------------------------------------
// Register word addresses
// ----------------------------------------
`define CZC_A_CTRL 4'h0
`define CZC_A_PTYPE 4'h1
`define CZC_A_RSPD 4'h2
`define CZC_A_BSPD 4'h3
`define CZC_A_OUTV 4'h4
`define CZC_A_HSO 4'h5
`define CZC_A_INV 4'h6
`define CZC_A_HSI 4'h7
`define CZC_A_NODE 4'h8
`define CZC_A_EPR 4'h9
`define CZC_A_STAT 4'hA
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CZC_B_MODE 0
`define CZC_B_REL_LO 1
`define CZC_B_REL_HI 2
`define CZC_B_WDACT 3
`define CZC_B_GBYP 4
`define CZC_MODE_MAN 1'h0
`define CZC_MODE_ACC 1'h1
`define CZC_PT_DRV 2'h0
`define CZC_PT_UP 2'h1
`define CZC_PT_DN 2'h2
`define CZC_SPD_MAX 13'h1FFF
`define CZC_NODE_RST 6'h3F
// ----------------------------------------
// Timing
// ----------------------------------------
`define CZC_CLK_HZ 25000000
`define CZC_POLL_TMO_S 10
`define CZC_MS_PER_S 1000
`define CZC_EPR_RST 16'h2710
`endif

//--- inc/czc_pkg.sv
package czc_pkg;
	typedef struct packed {
		logic [3:0] hs;
		logic [3:0] fault;
		logic [3:0] dir;
	} czc_pins_in_t;
	typedef struct packed {
		logic [3:0] hs;
		logic [3:0] run;
		logic [3:0] byp;
		logic [3:0] dir;
		logic [3:0] fault;
	} czc_pins_out_t;
	typedef enum logic [1:0] {
		CZC_REL_SING = 2'b00,
		CZC_REL_QUICK = 2'b01,
		CZC_REL_TRAIN = 2'b10
	} czc_rel_t;
	typedef enum logic [1:0] {
		CZC_WD_IDLE = 2'b00,
		CZC_WD_LIVE = 2'b01,
		CZC_WD_TRIP = 2'b10
	} czc_wd_t;
endpackage

//--- testbench/czc_top_bench.sv
`timescale 1ns/1ns
`include "czc_defines.svh"
module czc_top_bench;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] o_rdata;
	czc_pkg::czc_pins_in_t i_pins;
	czc_pkg::czc_pins_out_t o_pins;
	logic [12:0] o_speed;
	logic o_wd_trip;
	logic [3:0] sens = 4'h0;
	logic [3:0] flt = 4'h0;
	logic [3:0] dir = 4'h0;
	logic [3:0] moving;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #20 i_sys_clk = ~i_sys_clk;
	czc_top #(.P_MS_CYC(4)) czc_top_inst (.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pins(i_pins),
		.o_pins(o_pins), .o_speed(o_speed), .o_wd_trip(o_wd_trip));
	czc_zone_model czc_zone_model_inst (.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n), .i_sensor(sens), .i_fault(flt), .i_dir(dir),
		.i_out(o_pins), .o_in(i_pins), .o_moving(moving));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
	begin
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	end
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
	begin
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		chk("rdata", exp, o_rdata);
	end
	endtask
	// Pins pass a synchroniser and filter, so allow them to settle
	task automatic settle();
	begin
		repeat (8) @(posedge i_sys_clk);
		#1;
	end
	endtask
	task automatic give_verdict();
	begin
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
	begin
		rd(`CZC_A_CTRL, 16'h0000);
		rd(`CZC_A_NODE, 16'h003F);
		rd(`CZC_A_EPR, `CZC_EPR_RST);
		rd(4'hB, 16'h0000);
		$display("test reset done");
	end
	endtask
	task automatic t_echo();
	begin
		dir <= 4'h6;
		flt <= 4'h9;
		sens <= 4'h3;
		settle();
		chk("dir", 16'h0006, {12'h0, o_pins.dir});
		chk("fault", 16'h0009, {12'h0, o_pins.fault});
		rd(`CZC_A_INV, 16'h0693);
		dir <= 4'h0;
		flt <= 4'h0;
		sens <= 4'h0;
		$display("test echo done");
	end
	endtask
	task automatic t_manual();
	begin
		wr(`CZC_A_PTYPE, 16'h0024);
		rd(`CZC_A_PTYPE, 16'h0024);
		wr(`CZC_A_OUTV, 16'hA5C3);
		settle();
		chk("run", 16'h000C, {12'h0, o_pins.run});
		chk("byp", 16'h0005, {12'h0, o_pins.byp});
		chk("dirout", 16'h0008, {12'h0, o_pins.dir});
		chk("hsout", 16'h0002, {12'h0, o_pins.hs});
		wr(`CZC_A_OUTV, 16'h0000);
		$display("test manual done");
	end
	endtask
	task automatic t_speed();
	begin
		wr(`CZC_A_RSPD, 16'hFFFF);
		rd(`CZC_A_RSPD, 16'h1FFF);
		wr(`CZC_A_RSPD, 16'h0064);
		wr(`CZC_A_BSPD, 16'h3000);
		rd(`CZC_A_BSPD, 16'h1FFF);
		settle();
		chk("speed", 16'h0064, {3'h0, o_speed});
		wr(`CZC_A_CTRL, 16'h0010);
		settle();
		chk("speed", 16'h1FFF, {3'h0, o_speed});
		wr(`CZC_A_CTRL, 16'h0000);
		$display("test speed done");
	end
	endtask
	task automatic t_accum();
		logic [1:0] m;
	begin
		// Zones 1 and 2 full, zone 3 clear: zone 2 releases
		sens <= 4'h3;
		for (int k = 0; k < 3; k++)
		begin
			m = k[1:0];
			wr(`CZC_A_CTRL, {13'h0, m, 1'b1});
			settle();
			chk("run2", 16'h0001, {15'h0, o_pins.run[1]});
			chk("run1", {15'h0, k != 0}, {15'h0, o_pins.run[0]});
		end
		rd(`CZC_A_HSI, 16'h0000);
		sens <= 4'h8;
		wr(`CZC_A_HSO, 16'h0001);
		settle();
		rd(`CZC_A_HSI, 16'h0003);
		wr(`CZC_A_OUTV, 16'h0050);
		wr(`CZC_A_CTRL, 16'h0011);
		settle();
		chk("purge", 16'h0005, {12'h0, o_pins.run});
		chk("moving", 16'h0005, {12'h0, moving});
		wr(`CZC_A_CTRL, 16'h0001);
		sens <= 4'h0;
		$display("test accum done");
	end
	endtask
	task automatic t_watchdog();
	begin
		// Poll before shrinking the rate so no stale count trips early
		wr(`CZC_A_CTRL, 16'h0008);
		wr(`CZC_A_OUTV, 16'h0050);
		wr(`CZC_A_EPR, 16'h0003);
		wr(`CZC_A_HSO, 16'h0000);
		#1;
		chk("wd", 16'h0000, {15'h0, o_wd_trip});
		repeat (20) @(posedge i_sys_clk);
		#1;
		chk("wd", 16'h0001, {15'h0, o_wd_trip});
		chk("hold", 16'h0005, {12'h0, o_pins.run});
		rd(`CZC_A_STAT, 16'h0003);
		wr(`CZC_A_CTRL, 16'h0000);
		settle();
		chk("drop", 16'h0000, {12'h0, o_pins.run});
		wr(`CZC_A_HSO, 16'h0000);
		settle();
		chk("wd", 16'h0000, {15'h0, o_wd_trip});
		chk("run", 16'h0005, {12'h0, o_pins.run});
		$display("test watchdog done");
	end
	endtask
	always @(posedge i_sys_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (5) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_echo();
		t_manual();
		t_speed();
		t_accum();
		t_watchdog();
		give_verdict();
	end
endmodule // czc_top_bench

//--- testbench/czc_zone_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Far-side zone and driver modules
// ----------------------------------------
module czc_zone_model (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_sensor,
	input wire logic [3:0] i_fault,
	input wire logic [3:0] i_dir,
	input wire czc_pkg::czc_pins_out_t i_out,
	output czc_pkg::czc_pins_in_t o_in,
	output logic [3:0] o_moving
);
	logic byp_q_r;
	assign o_in.hs = i_sensor;
	assign o_in.fault = i_fault;
	assign o_in.dir = i_dir;
	// Motors follow run; when the last bypass line drops, every module stops for a cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			byp_q_r <= 1'b0;
			o_moving <= 4'h0;
		end
		else
		begin
			byp_q_r <= |i_out.byp;
			o_moving <= (byp_q_r && !(|i_out.byp)) ? 4'h0
				: i_out.run;
		end
	end
endmodule // czc_zone_model
